/* src/bfc_map.vh */
// Constants for the burst FIFO control state machine.
// Assumes one 250 MHz clock and plain Verilog-2005 users.
//
// What this block does
// R1: State bits: 00 empty, 01 near latch, 11 both, 10 far latch only.
// R2: State changes only on poll strobe rise or gated data strobe rise.
// R3: Gated data strobe is data strobe qualified by the data path decode.
// R4: Both strobe edges merge into one state clock; delayed copy samples readiness.
// R5: Poll-edge flag high before poll clocks; gated strobe fall clears it.
// R6: Readiness is accept flag outward, source flag inward, chosen by direction.
// R7: Readiness is sampled nominally 150 ns after each state clock.
// R8: Active-low flush forces both state bits to zero on next state clock.
// R9: Direction comes only from the control bit, never the backplane line.
// R10: Push only outward, ready, not near-full on data clock, not empty on poll.
// R11: Push pulse set by state clock, cleared after a fixed delay.
// R12: Outward streaming stays in 00 with input latch open, burst requested.
// R13: Outward data clock with readiness false moves 00 to 01, no push.
// R14: Entering 01 outward withdraws burst request and closes input latch.
// R15: Adapter sends at most one word after burst withdrawn; the 32-word burst cap is not enforced.
// R16: Outward, no group 0 poll reply while any latch holds data.
// R17: Ready poll clocks drain latches 11 to 10 to 00; not ready holds.
// R18: Outward 00 with replies enabled drives service request during poll.
// R19: Burst request only in 00 outward or 11 inward.
// R20: Poll reply needs enable, group 0 and qualifying state, or attention term.
// R21: Direction 1 is outward to peripheral, 0 is inward to backplane.
// R22: Flush control written 0 resets the queue and its state machine.
// R23: Pop blocked outward, not ready, far-only, or far full on poll clock.
// R24: Output latch clock pulses on pop and on inward 01 to 10 step.
// R25: After reset state is 00 and burst stays off until flush released.
`ifndef BFC_MAP_VH
`define BFC_MAP_VH

// Clock period and delays in nanoseconds.
`define BFC_CLK_NS 4
`define BFC_SAMPLE_NS 150
`define BFC_PULSE_NS 20

// State bit values.
`define BFC_ST_EMPTY 2'h0
`define BFC_ST_NEAR 2'h1
`define BFC_ST_BOTH 2'h3
`define BFC_ST_FAR 2'h2

// Direction control values.
`define BFC_DIR_OUT 1'h1
`define BFC_DIR_IN 1'h0

// Buffer and word sizes.
`define BFC_WORD_W 18
`define BFC_BUF_DEPTH 2
`define BFC_BURST_MAX 32

`endif

/* src/bfc_burst_fifo_ctl.v */
// Burst FIFO control state machine with a two-entry word buffer.
// Assumes all inputs are synchronous to clock and strobes are active low.
`timescale 1ns/1ps
`default_nettype none
`include "bfc_map.vh"

module bfc_burst_fifo_ctl #(
   parameter WORD_W = `BFC_WORD_W,
   parameter PULSE_NS = `BFC_PULSE_NS
) (
   // Clock and reset.
   input wire clock,
   input wire reset,
   // Control bits.
   input wire direction_ctl,
   input wire queue_flush_ctl,
   input wire poll_reply_enable,
   // Backplane strobes and decode.
   input wire poll_strobe_n,
   input wire backplane_data_strobe_n,
   input wire data_path_select,
   input wire service_poll,
   input wire poll_group_line_0,
   input wire poll_group_line_1,
   input wire attention_request,
   // FIFO flags.
   input wire fifo_can_accept,
   input wire fifo_can_source,
   // Incoming data words.
   input wire [WORD_W-1:0] data_in,
   output wire data_in_ready,
   // Words towards the FIFO.
   output wire [WORD_W-1:0] fifo_word,
   output wire fifo_word_valid,
   input wire fifo_word_ready,
   // Control outputs.
   output wire far_latch_full,
   output wire near_latch_full,
   output wire poll_edge_next,
   output wire sampled_fifo_ready,
   output wire push_trigger,
   output wire pop_trigger_n,
   output wire push_pulse,
   output wire pop_pulse,
   output wire output_latch_clock,
   output wire input_latch_enable,
   output wire burst_request_n,
   output wire poll_reply_drive,
   output wire service_request_line_out,
   output wire service_request_line_oe
);

   // =====================================================
   // Timing counts.
   // =====================================================

   // Readiness sample point, nominal value rounded down.
   localparam integer SAMPLE_CYC = `BFC_SAMPLE_NS / `BFC_CLK_NS;
   localparam integer PULSE_CYC = (PULSE_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS;
   localparam [5:0] SAMPLE_LAST = SAMPLE_CYC[5:0];
   localparam [5:0] PULSE_LAST = PULSE_CYC[5:0];

   // =====================================================
   // Strobe edges and the merged state clock.
   // =====================================================

   reg poll_q;
   reg gated_q;
   wire gated_data_strobe_n;
   wire poll_rise;
   wire gated_rise;
   wire gated_fall;
   wire state_clock;

   // Data strobe passes only for data path transfers.
   assign gated_data_strobe_n = backplane_data_strobe_n | ~data_path_select; // R3

   // Previous strobe levels for edge detection.
   always @(posedge clock) begin
      if (reset) begin
         poll_q <= 1'h1;
         gated_q <= 1'h1;
      end else begin
         poll_q <= poll_strobe_n;
         gated_q <= gated_data_strobe_n;
      end
   end

   // Either rising edge is a state clock; the sources never overlap.
   assign poll_rise = poll_strobe_n & ~poll_q;
   assign gated_rise = gated_data_strobe_n & ~gated_q;
   assign gated_fall = ~gated_data_strobe_n & gated_q;
   assign state_clock = poll_rise | gated_rise; // R2 R4

   // =====================================================
   // Poll-edge flag.
   // =====================================================

   reg pt;

   // Set after a data clock, cleared when a data strobe begins.
   always @(posedge clock) begin
      if (reset) begin
         pt <= 1'h1;
      end else if (gated_fall) begin
         pt <= 1'h0; // R5
      end else if (gated_rise) begin
         pt <= 1'h1;
      end
   end

   assign poll_edge_next = pt;

   // =====================================================
   // Readiness sampling.
   // =====================================================

   reg sr;
   reg [5:0] sample_cnt;
   reg sample_busy;
   wire ready_sel;

   // Direction control alone selects the flag.
   assign ready_sel = (direction_ctl == `BFC_DIR_OUT) ?
      fifo_can_accept : fifo_can_source; // R6 R9 R21

   // Delayed copy of the state clock samples readiness.
   always @(posedge clock) begin
      if (reset) begin
         sr <= 1'h0;
         sample_cnt <= 6'h00;
         sample_busy <= 1'h0;
      end else if (state_clock) begin
         sample_cnt <= 6'h00;
         sample_busy <= 1'h1;
      end else if (sample_busy) begin
         if (sample_cnt == SAMPLE_LAST - 6'h01) begin
            sr <= ready_sel; // R7
            sample_busy <= 1'h0;
         end else begin
            sample_cnt <= sample_cnt + 6'h01;
         end
      end
   end

   assign sampled_fifo_ready = sr;

   // =====================================================
   // Next state and triggers.
   // =====================================================

   reg y1;
   reg y0;
   reg armed;
   wire dir;
   wire buf_ready;
   reg next_y1;
   reg next_y0;

   assign dir = direction_ctl; // R9

   // Latch occupancy equations.
   always @* begin
      next_y1 = ~((~y1 & ~y0) | (~pt & ~y0) | (~y1 & pt & dir)
         | (~y0 & pt & dir & sr)); // R1 R13 R17
      next_y0 = ~((~dir & ~pt & ~sr) | (dir & sr & pt) | (dir & sr & ~y0)
         | (~dir & ~sr & ~y1) | (dir & pt & ~y0) | (~y0 & y1)); // R12 R13
   end

   // Push needs room in the word buffer as well.
   assign push_trigger = dir & sr & buf_ready & ~(y0 & ~pt)
      & ~(~y0 & ~y1 & pt); // R10
   assign pop_trigger_n = ~((~dir & sr & y0 & ~pt) | (~dir & sr & ~y1)); // R23

   // State register, flushed on a state clock while flush is low.
   always @(posedge clock) begin
      if (reset) begin
         y1 <= 1'h0;
         y0 <= 1'h0; // R25
      end else if (state_clock) begin
         if (!queue_flush_ctl) begin
            y1 <= 1'h0; // R8 R22
            y0 <= 1'h0;
         end else begin
            y1 <= next_y1;
            y0 <= next_y0;
         end
      end
   end

   // Burst stays off after reset until flush has been released.
   always @(posedge clock) begin
      if (reset) begin
         armed <= 1'h0;
      end else begin
         armed <= queue_flush_ctl; // R25
      end
   end

   assign far_latch_full = y1;
   assign near_latch_full = y0;

   // =====================================================
   // Pulse generators.
   // =====================================================

   wire [2:0] pulse_start;
   wire [2:0] pulse_out;
   wire step_fwd;

   // Inward move of a word from the near to the far latch.
   assign step_fwd = ~dir & y0 & ~y1 & next_y1 & ~next_y0; // R24
   assign pulse_start[0] = state_clock & push_trigger & queue_flush_ctl; // R10
   assign pulse_start[1] = state_clock & ~pop_trigger_n & queue_flush_ctl;
   assign pulse_start[2] = pulse_start[1]
      | (state_clock & step_fwd & queue_flush_ctl); // R24

   // Each pulse is set by the clock and cleared after its delay.
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_pulse
         reg on;
         reg [5:0] cnt;
         always @(posedge clock) begin
            if (reset) begin
               on <= 1'h0;
               cnt <= 6'h00;
            end else if (pulse_start[gi]) begin
               on <= 1'h1;
               cnt <= 6'h00;
            end else if (on) begin
               if (cnt == PULSE_LAST - 6'h01) begin
                  on <= 1'h0; // R11
               end else begin
                  cnt <= cnt + 6'h01;
               end
            end
         end
         assign pulse_out[gi] = on;
      end
   endgenerate

   assign push_pulse = pulse_out[0];
   assign pop_pulse = pulse_out[1];
   assign output_latch_clock = pulse_out[2]; // R24

   // =====================================================
   // Latch enable, burst request and poll reply.
   // =====================================================

   // Input latch is open only while the near latch is free.
   assign input_latch_enable = dir & ~y0; // R12 R14

   // Burst only in empty outward or full inward states.
   assign burst_request_n = ~(armed & ((dir & ~y1 & ~y0)
      | (~dir & y1 & y0))); // R19 R14

   // Group 0 reply for qualifying states, plus attention term.
   assign poll_reply_drive = (poll_reply_enable & ~poll_group_line_0
      & ~poll_group_line_1 & ((dir & ~y1 & ~y0) | (~dir & (y1 | y0))))
      | (~poll_group_line_0 & poll_group_line_1 & attention_request); // R16 R20

   // Open-drain service request, pulled low during the poll.
   assign service_request_line_out = 1'h0;
   assign service_request_line_oe = service_poll & poll_reply_drive; // R18

   // =====================================================
   // Two-entry word buffer towards the FIFO.
   // =====================================================

   reg [WORD_W-1:0] mem [0:`BFC_BUF_DEPTH-1];
   reg wr_ptr;
   reg rd_ptr;
   reg [1:0] count;
   wire do_wr;
   wire do_rd;

   assign buf_ready = (count != 2'h2);
   assign data_in_ready = buf_ready;
   assign fifo_word_valid = (count != 2'h0);
   assign fifo_word = mem[rd_ptr];
   assign do_wr = pulse_start[0];
   assign do_rd = fifo_word_valid & fifo_word_ready;

   // Words are captured on each push and drained by the FIFO side.
   always @(posedge clock) begin
      if (reset) begin
         wr_ptr <= 1'h0;
         rd_ptr <= 1'h0;
         count <= 2'h0;
      end else begin
         if (do_wr) begin
            mem[wr_ptr] <= data_in;
            wr_ptr <= ~wr_ptr;
         end
         if (do_rd) begin
            rd_ptr <= ~rd_ptr;
         end
         if (do_wr & ~do_rd) begin
            count <= count + 2'h1;
         end else if (do_rd & ~do_wr) begin
            count <= count - 2'h1;
         end
      end
   end

endmodule

`default_nettype wire

/* sim/bfc_adapter_model.sv */
// Behavioural backplane channel adapter that polls the card and sends data words.
// Assumes the bench calls its tasks from code aligned to falling clock edges.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Adapter model.
module bfc_adapter_model (
   // Clock and burst request from the card.
   input wire logic clock,
   input wire logic burst_request_n,
   // Strobes, decode and data towards the card.
   output logic poll_strobe_n,
   output logic backplane_data_strobe_n,
   output logic data_path_select,
   output logic [17:0] data_in
);
   int late_words = 0;
   // Lines start idle and deselected.
   initial begin
      poll_strobe_n = 1'b1;
      backplane_data_strobe_n = 1'b1;
      data_path_select = 1'b0;
      data_in = 18'h15555;
   end
   // One poll, then time for the readiness sample to settle.
   task automatic poll();
      @(negedge clock);
      poll_strobe_n = 1'b0;
      repeat (3) @(negedge clock);
      poll_strobe_n = 1'b1;
      repeat (45) @(negedge clock);
   endtask
   // One data word; after burst withdrawal only one late word may follow.
   task automatic send(input logic [17:0] w, input logic sel);
      if (burst_request_n) late_words++;
      else late_words = 0;
      if (late_words < 2) begin
         @(negedge clock);
         data_in = w;
         data_path_select = sel;
         backplane_data_strobe_n = 1'b0;
         repeat (3) @(negedge clock);
         backplane_data_strobe_n = 1'b1;
         repeat (45) @(negedge clock);
         data_path_select = 1'b0;
         data_in = ~w;
      end
   endtask
endmodule
`default_nettype wire

/* sim/bfc_ctl_assertions.sv */
// Port checker for the burst FIFO control state machine.
// Assumes it is bound into bfc_burst_fifo_ctl, one clock domain.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker.
module bfc_ctl_check (
   // Clock, reset and inputs.
   input wire clock,
   input wire reset,
   input wire direction_ctl,
   input wire queue_flush_ctl,
   input wire poll_reply_enable,
   input wire poll_strobe_n,
   input wire backplane_data_strobe_n,
   input wire poll_group_line_0,
   input wire poll_group_line_1,
   input wire attention_request,
   // Watched outputs.
   input wire far_latch_full,
   input wire near_latch_full,
   input wire poll_edge_next,
   input wire sampled_fifo_ready,
   input wire push_trigger,
   input wire pop_trigger_n,
   input wire push_pulse,
   input wire input_latch_enable,
   input wire burst_request_n,
   input wire poll_reply_drive
);
   // State bits as one value.
   wire [1:0] st = {far_latch_full, near_latch_full};
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   a_reset_idle: assert property ($fell(reset) |-> st == 2'h0 && burst_request_n)
      else $error("State or burst request not idle after reset.");
   a_burst_cases: assert property (!burst_request_n |->
      (direction_ctl && st == 2'h0) || (!direction_ctl && st == 2'h3))
      else $error("Burst request in a wrong state.");
   a_latch_open: assert property (
      input_latch_enable == (direction_ctl && !near_latch_full))
      else $error("Input latch enable wrong.");
   a_push_gate: assert property (push_trigger |-> direction_ctl && sampled_fifo_ready &&
      !(near_latch_full && !poll_edge_next) && !(st == 2'h0 && poll_edge_next))
      else $error("Push trigger without cause.");
   a_pop_gate: assert property (!pop_trigger_n |-> !direction_ctl && sampled_fifo_ready &&
      st != 2'h2 && !(far_latch_full && poll_edge_next))
      else $error("Pop trigger while blocked.");
   a_push_width: assert property ($rose(push_pulse) |-> push_pulse[*5] ##1 !push_pulse)
      else $error("Push pulse width wrong.");
   a_state_quiet: assert property (
      (poll_strobe_n && backplane_data_strobe_n)[*6] |-> $stable(st))
      else $error("State moved without a strobe.");
   a_flush_clear: assert property (!queue_flush_ctl && !$past(queue_flush_ctl) &&
      !$past(queue_flush_ctl, 2) && !$stable(st) |-> st == 2'h0)
      else $error("Flush did not clear state.");
   a_reply_terms: assert property (poll_reply_drive |-> (poll_reply_enable &&
      !poll_group_line_0 && !poll_group_line_1 && (direction_ctl == (st == 2'h0))) ||
      (!poll_group_line_0 && poll_group_line_1 && attention_request))
      else $error("Poll reply without cause.");
   c_push: cover property ($rose(push_pulse));
   c_both_burst: cover property (st == 2'h3 && !burst_request_n);
   c_reply: cover property (poll_reply_drive);
endmodule
bind bfc_burst_fifo_ctl bfc_ctl_check bfc_ctl_check_inst (.clock, .reset, .direction_ctl,
   .queue_flush_ctl, .poll_reply_enable, .poll_strobe_n, .backplane_data_strobe_n,
   .poll_group_line_0, .poll_group_line_1, .attention_request, .far_latch_full,
   .near_latch_full, .poll_edge_next, .sampled_fifo_ready, .push_trigger, .pop_trigger_n,
   .push_pulse, .input_latch_enable, .burst_request_n, .poll_reply_drive);
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the burst FIFO control state machine.
// Assumes the adapter model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench top.
module tb_top;
   logic clock = 1'b0, reset = 1'b1, direction_ctl = 1'b1, queue_flush_ctl = 1'b0;
   logic poll_reply_enable = 1'b1, service_poll = 1'b0, attention_request = 1'b0;
   logic poll_group_line_0 = 1'b0, poll_group_line_1 = 1'b0, fifo_word_ready = 1'b0;
   logic fifo_can_accept = 1'b1, fifo_can_source = 1'b0, rdy_rand = 1'b0;
   logic push_q = 1'b0, pop_q = 1'b0, lck_q = 1'b0;
   logic [17:0] rs = 18'h15079;
   logic [17:0] exp_q[$];
   int mismatches = 0, total_checks = 0, pushes = 0, pops = 0, lcks = 0;
   wire poll_strobe_n, backplane_data_strobe_n, data_path_select, data_in_ready, push_pulse;
   wire fifo_word_valid, far_latch_full, near_latch_full, sampled_fifo_ready, pop_pulse;
   wire output_latch_clock, input_latch_enable, burst_request_n, service_request_line_oe;
   wire service_request_line_out;
   wire [17:0] data_in, fifo_word;
   wire [1:0] st = {far_latch_full, near_latch_full};
   // Clock of 4 ns period.
   always #2 clock = ~clock;
   // Count pulse starts and compare words leaving the buffer.
   always @(posedge clock) begin
      push_q <= push_pulse;
      pop_q <= pop_pulse;
      lck_q <= output_latch_clock;
      if (push_pulse === 1'b1 && push_q === 1'b0) pushes++;
      if (pop_pulse === 1'b1 && pop_q === 1'b0) pops++;
      if (output_latch_clock === 1'b1 && lck_q === 1'b0) lcks++;
      if (fifo_word_valid === 1'b1 && fifo_word_ready && exp_q.size() > 0)
         check_val(fifo_word, exp_q.pop_front());
   end
   // Random stalls of the receiver.
   always @(negedge clock) begin
      if (rdy_rand) begin
         rs = lfsr(rs);
         fifo_word_ready <= rs[0];
      end
   end
   bfc_adapter_model bfc_adapter_model_inst (.clock, .burst_request_n, .poll_strobe_n,
      .backplane_data_strobe_n, .data_path_select, .data_in);
   bfc_burst_fifo_ctl #(.WORD_W(18)) bfc_burst_fifo_ctl_inst (.clock, .reset, .direction_ctl,
      .queue_flush_ctl, .poll_reply_enable, .poll_strobe_n, .backplane_data_strobe_n,
      .data_path_select, .service_poll, .poll_group_line_0, .poll_group_line_1,
      .attention_request, .fifo_can_accept, .fifo_can_source, .data_in, .data_in_ready,
      .fifo_word, .fifo_word_valid, .fifo_word_ready, .far_latch_full, .near_latch_full,
      .poll_edge_next(), .sampled_fifo_ready, .push_trigger(), .pop_trigger_n(), .push_pulse,
      .pop_pulse, .output_latch_clock, .input_latch_enable, .burst_request_n,
      .poll_reply_drive(), .service_request_line_out, .service_request_line_oe);
   // Next value of the stimulus shift register.
   function automatic logic [17:0] lfsr(input logic [17:0] v);
      return {v[16:0], v[17] ^ v[10]};
   endfunction
   // Compare one flag.
   task automatic check_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Compare a word, a state or a count.
   task automatic check_val(input logic [17:0] got, input logic [17:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Run a service poll and look at the request line enable.
   task automatic srq(input logic exp);
      @(negedge clock);
      service_poll = 1'b1;
      @(negedge clock);
      check_bit(service_request_line_oe, exp);
      check_bit(service_request_line_out, 1'b0);
      service_poll = 1'b0;
   endtask
   // Print the verdict and stop.
   task automatic close_out();
      if (mismatches == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Main sequence: stream out, fill and drain, then stream in and flush.
   initial begin
      repeat (8) @(negedge clock);
      reset = 1'b0;
      check_bit(burst_request_n, 1'b1);
      queue_flush_ctl = 1'b1;
      bfc_adapter_model_inst.poll();
      check_val(18'(st), 18'h0);
      check_bit(burst_request_n, 1'b0);
      srq(1'b1);
      for (int i = 0; i < 3; i++) begin
         rs = lfsr(rs);
         if (i == 0) rs = 18'h3FFFF;
         if (i < 2) exp_q.push_back(rs);
         bfc_adapter_model_inst.send(rs, 1'b1);
         check_val(18'(st), 18'h0);
      end
      check_val(18'(pushes), 18'h2);
      check_bit(data_in_ready, 1'b0);
      bfc_adapter_model_inst.send(rs, 1'b0);
      check_val(18'(pushes), 18'h2);
      rdy_rand = 1'b1;
      repeat (40) @(negedge clock);
      rdy_rand = 1'b0;
      // Let the random driver's last update land before taking over the ready line.
      @(negedge clock);
      fifo_word_ready = 1'b1;
      repeat (2) @(negedge clock);
      check_val(18'(exp_q.size()), 18'h0);
      fifo_can_accept = 1'b0;
      bfc_adapter_model_inst.poll();
      check_bit(sampled_fifo_ready, 1'b0);
      bfc_adapter_model_inst.send(rs, 1'b1);
      check_val(18'(st), 18'h1);
      check_bit(burst_request_n, 1'b1);
      check_bit(input_latch_enable, 1'b0);
      bfc_adapter_model_inst.send(~rs, 1'b1);
      check_val(18'(st), 18'h3);
      srq(1'b0);
      fifo_can_accept = 1'b1;
      for (int i = 0; i < 3; i++) begin
         bfc_adapter_model_inst.poll();
         check_val(18'(st), (i == 0) ? 18'h3 : (i == 1) ? 18'h2 : 18'h0);
         check_val(18'(pushes), 18'(2 + i));
         srq(i == 2);
      end
      direction_ctl = 1'b0;
      fifo_can_source = 1'b1;
      bfc_adapter_model_inst.poll();
      check_val(18'(st), 18'h1);
      srq(1'b1);
      fifo_can_source = 1'b0;
      bfc_adapter_model_inst.poll();
      check_val(18'(st), 18'h3);
      check_bit(burst_request_n, 1'b0);
      check_bit(sampled_fifo_ready, 1'b0);
      check_val(18'(pops), 18'h2);
      check_val(18'(lcks), 18'h2);
      bfc_adapter_model_inst.send(rs, 1'b1);
      check_val(18'(st), 18'h2);
      check_val(18'(pops), 18'h2);
      poll_reply_enable = 1'b0;
      poll_group_line_1 = 1'b1;
      attention_request = 1'b1;
      srq(1'b1);
      poll_group_line_0 = 1'b1;
      srq(1'b0);
      queue_flush_ctl = 1'b0;
      bfc_adapter_model_inst.poll();
      check_val(18'(st), 18'h0);
      // Inward again: one pop into the near latch, then a step to the far latch.
      queue_flush_ctl = 1'b1;
      fifo_can_source = 1'b1;
      bfc_adapter_model_inst.poll();
      check_val(18'(st), 18'h0);
      fifo_can_source = 1'b0;
      bfc_adapter_model_inst.poll();
      check_val(18'(st), 18'h1);
      bfc_adapter_model_inst.poll();
      check_val(18'(st), 18'h2);
      check_val(18'(pops), 18'h3);
      check_val(18'(lcks), 18'h4);
      close_out();
   end
   // Cut a hang short.
   initial begin
      repeat (6000) @(posedge clock);
      mismatches++;
      close_out();
   end
endmodule
`default_nettype wire
